// ===== gauge_pkg.sv
// Shared constants and types for the gauge housekeeping scheduler
package gauge_pkg;
   localparam int unsigned CLK_HZ      = 250_000_000;
   localparam int unsigned LFO_HZ      = 32_768;
   localparam int unsigned T_CYCLE_S   = 1;
   localparam int unsigned T_BUSOFF_S  = 2;
   localparam int unsigned T_AUTOCAL_S = 5;
   localparam int unsigned T_IDLE_MS   = 50;
   localparam int unsigned T_READY_MS  = 1;
   // Main clock counts; a longest time rounds down
   localparam int unsigned CYC_1S      = CLK_HZ * T_CYCLE_S;
   localparam int unsigned CYC_READY   = CLK_HZ / 1000 * T_READY_MS;
   // Low-frequency oscillator counts; a least time rounds up
   localparam int unsigned LF_BUSOFF   = LFO_HZ * T_BUSOFF_S;
   localparam int unsigned LF_AUTOCAL  = LFO_HZ * T_AUTOCAL_S;
   localparam int unsigned LF_IDLE     = (LFO_HZ * T_IDLE_MS + 999) / 1000;
   // Integrator step, in hundredths of a nanovolt-hour
   localparam int unsigned CC_LSB_NVH_X100 = 65;
   localparam int          CELLS       = 4;
   localparam int          CELL_W      = 16;
   localparam int          CC_W        = 48;
   localparam int          GAIN_SHIFT  = 15;
   localparam int          LOW_W       = 18;
   localparam int          HIGH_W      = 11;
   localparam logic [7:0]  SLP_MIN     = 8'h01;
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h1,
      MODE_SLEEP  = 3'h2,
      MODE_SHUT   = 3'h4
   } power_mode_t;
endpackage

// ===== bus_line_monitor.sv
// Bus line low/high duration monitor on the low-frequency oscillator
`timescale 1ns/1ns
module bus_line_monitor #(
   parameter int unsigned BUSOFF_CNT  = gauge_pkg::LF_BUSOFF,
   parameter int unsigned AUTOCAL_CNT = gauge_pkg::LF_AUTOCAL
) (
   input  wire logic lfo_clk_in,      // Always-running slow clock
   input  wire logic resetn_in,       // Async reset, active low
   input  wire logic bus_clk_in,      // Bus clock line level
   input  wire logic bus_data_in,     // Bus data line level
   output logic      bus_off_out,     // Bus-off state level
   output logic      bus_idle_out,    // Both lines high too long
   output logic      autocal_tgl_out  // Toggles per calibration start
);
   logic [1:0]                    sc_q, sd_q;
   logic [gauge_pkg::LOW_W-1:0]   low_q, low_d;
   logic [gauge_pkg::HIGH_W-1:0]  high_q, high_d;
   logic                          off_d, idle_d, tgl_d;
   logic                          both_low, both_high;

   always_comb begin
      both_low  = !sc_q[1] && !sd_q[1];
      both_high = sc_q[1] && sd_q[1];
      // Either line high restarts the low timer [R18]
      low_d = '0;
      if (both_low) begin
         low_d = (low_q == gauge_pkg::LOW_W'(AUTOCAL_CNT)) ? low_q
                 : low_q + 1'b1;
      end
      high_d = '0;
      if (both_high) begin
         high_d = (high_q == gauge_pkg::HIGH_W'(gauge_pkg::LF_IDLE)) ?
                  high_q : high_q + 1'b1;
      end
      off_d  = both_low && (low_d >= gauge_pkg::LOW_W'(BUSOFF_CNT)); // [R10] [R11]
      idle_d = high_d >= gauge_pkg::HIGH_W'(gauge_pkg::LF_IDLE);    // [R17]
      tgl_d  = autocal_tgl_out ^ (both_low &&
               low_q == gauge_pkg::LOW_W'(AUTOCAL_CNT - 1));        // [R9]
   end

   always_ff @(posedge lfo_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sc_q            <= 2'h0;
         sd_q            <= 2'h0;
         low_q           <= '0;
         high_q          <= '0;
         bus_off_out     <= 1'b0;
         bus_idle_out    <= 1'b0;
         autocal_tgl_out <= 1'b0;
      end else begin
         sc_q            <= {sc_q[0], bus_clk_in};
         sd_q            <= {sd_q[0], bus_data_in};
         low_q           <= low_d;
         high_q          <= high_d;
         bus_off_out     <= off_d;
         bus_idle_out    <= idle_d;
         autocal_tgl_out <= tgl_d;
      end
   end

   default clocking cb_lf @(posedge lfo_clk_in); endclocking
   default disable iff (!resetn_in);

   a_busoff_enter: assert property (both_low &&                    // [R10]
      low_q == gauge_pkg::LOW_W'(BUSOFF_CNT - 1) |=> bus_off_out)
      else $error("bus-off not entered at limit");
   a_busoff_leave: assert property (!both_low |=> !bus_off_out // [R11] [R18]
      && low_q == '0) else $error("bus-off kept after line high");
   a_autocal_start: assert property (both_low &&                   // [R9]
      low_q == gauge_pkg::LOW_W'(AUTOCAL_CNT - 1)
      |=> autocal_tgl_out != $past(autocal_tgl_out))
      else $error("calibration start missed");
   a_idle_detect: assert property (!both_high |=> !bus_idle_out)   // [R17]
      else $error("idle flagged with a line low");
   c_busoff: cover property (!bus_off_out ##1 bus_off_out);
endmodule

// ===== coulomb_integrator.sv
// Signed sense-sample integrator with charge/discharge classification
`timescale 1ns/1ns
module coulomb_integrator (
   input  wire logic                           clk_in,      // Main clock
   input  wire logic                           resetn_in,   // Reset, low
   input  wire logic                           en_in,       // Measuring
   input  wire logic                           valid_in,    // Sample strobe
   input  wire logic signed [15:0]             sample_in,   // Sense diff
   output logic signed [gauge_pkg::CC_W-1:0]   acc_out,     // Charge count
   output logic                                charge_out,  // Positive flow
   output logic                                discharge_out // Negative flow
);
   logic signed [gauge_pkg::CC_W-1:0] acc_d;
   logic                              chg_d, dis_d;
   logic                              take;

   always_comb begin
      take  = en_in && valid_in;
      acc_d = acc_out;
      chg_d = charge_out;
      dis_d = discharge_out;
      if (take) begin
         // Each count is one integrator step of signed charge [R7]
         acc_d = acc_out + gauge_pkg::CC_W'(sample_in);
         chg_d = sample_in > 16'sh0000;                            // [R6]
         dis_d = sample_in < 16'sh0000;                            // [R6]
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_out       <= '0;
         charge_out    <= 1'b0;
         discharge_out <= 1'b0;
      end else begin
         acc_out       <= acc_d;
         charge_out    <= chg_d;
         discharge_out <= dis_d;
      end
   end

   default clocking cb_cc @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   a_cc_accum: assert property (take |=> acc_out ==                // [R7]
      $past(acc_out) + gauge_pkg::CC_W'($past(sample_in)))
      else $error("integrator step wrong");
   a_cc_sign: assert property (take |=> (charge_out ==             // [R6]
      ($past(sample_in) > 0)) && (discharge_out == ($past(sample_in) < 0)))
      else $error("charge direction wrong");
   a_cc_hold: assert property (!en_in |=> $stable(acc_out))        // [R4]
      else $error("integrator moved while disabled");
endmodule

// ===== gauge_scheduler_bus_monitor.sv
// Power-mode scheduler, measurement housekeeping and bus-line supervision
`timescale 1ns/1ns
// Function
// R1: Normal mode runs one cycle per second
// R2: Sleep runs cycles at the configured interval
// R3: Current flow or fault wakes sleep
// R4: Shutdown stops measuring, cycling and bus activity; bus_abort_out is not gated by shutdown and still pulses on line idle
// R5: Sample presence pin each second, low means present
// R6: Positive sense is charge, negative is discharge
// R7: Integrate signed sense samples continuously
// R8: Refresh calibrated cell voltages every cycle
// R9: Both lines low five seconds starts calibration
// R10: Both lines low two seconds means bus-off
// R11: A line going high clears bus-off
// R12: Bus ready within 1 ms after bus-off
// R13: Serious fault drives fuse output
// R14: Broadcast charge current and voltage to charger
// R15: Packet error checking optional in both roles
// R16: Out-of-range temperature inhibits or suspends charging
// R17: Lines high over 50 ms abort transaction
// R18: Low timers restart on high, run slowly
module gauge_scheduler_bus_monitor #(
   parameter int unsigned SEC_CYCLES   = gauge_pkg::CYC_1S,
   parameter int unsigned READY_CYCLES = gauge_pkg::CYC_READY,
   parameter int unsigned BUSOFF_LF    = gauge_pkg::LF_BUSOFF,
   parameter int unsigned AUTOCAL_LF   = gauge_pkg::LF_AUTOCAL
) (
   input  wire logic        clk_in,               // 250 MHz main clock
   input  wire logic        resetn_in,            // Async reset, active low
   input  wire logic        lfo_clk_in,           // Slow oscillator clock
   input  wire logic        bus_clk_in,           // Bus clock line level
   input  wire logic        bus_data_in,          // Bus data line level
   input  wire logic        system_present_input, // Presence pin, low=host
   input  wire logic        sleep_req_in,         // Request sleep
   input  wire logic        shutdown_req_in,      // Request shutdown
   input  wire logic        wake_in,              // Leave shutdown
   input  wire logic [7:0]  sleep_secs_in,        // Sleep cycle interval, s
   input  wire logic        fault_in,             // First-level fault
   input  wire logic        fault2_in,            // Second-level fault
   input  wire logic        sense_valid_in,       // Sense sample strobe
   input  wire logic [15:0] sense_sample_in,      // Signed sense sample
   input  wire logic [63:0] cell_raw_in,          // Four raw cell readings
   input  wire logic [15:0] cell_gain_in,         // Cell gain, 1.15 format
   input  wire logic [15:0] cell_offset_in,       // Cell offset, mV
   input  wire logic [15:0] temp_in,              // Pack temperature
   input  wire logic [15:0] temp_min_in,          // Charge range low end
   input  wire logic [15:0] temp_max_in,          // Charge range high end
   input  wire logic [15:0] chg_current_in,       // Wanted charge current
   input  wire logic [15:0] chg_voltage_in,       // Wanted charge voltage
   input  wire logic        pec_enable_in,        // Use error check byte
   output logic [2:0]       mode_out,             // One-hot power mode
   output logic             cycle_out,            // Measurement cycle pulse
   output logic             low_power_out,        // Reduced power state
   output logic             present_out,          // Host present
   output logic             charge_out,           // Charge activity
   output logic             discharge_out,        // Discharge activity
   output logic [47:0]      coulomb_out,          // Integrated charge
   output logic [63:0]      cell_v_out,           // Calibrated cell volts
   output logic             autocal_out,          // Offset calibration pulse
   output logic             bus_off_out,          // Bus-off state
   output logic             bus_ready_out,        // Bus usable
   output logic             bus_abort_out,        // Transaction abort pulse
   output logic             safe_out,             // Fuse drive, sticky
   output logic             charge_inhibit_out,   // Charging inhibited
   output logic             bcast_req_out,        // Charger broadcast pulse
   output logic [15:0]      bcast_current_out,    // Broadcast current
   output logic [15:0]      bcast_voltage_out,    // Broadcast voltage
   output logic             pec_en_out            // Error check in use
);
   gauge_pkg::power_mode_t mode_q, mode_d;
   logic [31:0]            sec_q, sec_d;
   logic [7:0]             slp_q, slp_d;
   logic [7:0]             slp_eff;
   logic                   sec_tick, slp_last, cyc_now, shut;
   logic                   cycle_d, lowp_d;
   logic [1:0]             system_present_input_s_q;
   logic                   present_d;
   logic [63:0]            cal;
   logic [63:0]            cell_d;
   logic                   inh_d, out_range;
   logic                   bcast_d;
   logic [15:0]            bcur_d, bvol_d;
   logic                   safe_d;
   logic                   lf_off, lf_idle, lf_tgl;
   logic [2:0]             lnk1_q, lnk2_q;
   logic [1:0]             prev_q;
   logic                   off_d, ready_d, abort_d, autocal_d;
   logic                   cc_chg, cc_dis;
   logic [47:0]            cc_acc;
   logic [31:0]            rdy_wait_q, rdy_wait_d;

   bus_line_monitor #(
      .BUSOFF_CNT  (BUSOFF_LF),
      .AUTOCAL_CNT (AUTOCAL_LF)
   ) u_lines (
      .lfo_clk_in      (lfo_clk_in),
      .resetn_in       (resetn_in),
      .bus_clk_in      (bus_clk_in),
      .bus_data_in     (bus_data_in),
      .bus_off_out     (lf_off),
      .bus_idle_out    (lf_idle),
      .autocal_tgl_out (lf_tgl)
   );

   // Shutdown gates the integrator, so no charge is counted there
   coulomb_integrator u_cc (
      .clk_in        (clk_in),
      .resetn_in     (resetn_in),
      .en_in         (!shut),                                      // [R4]
      .valid_in      (sense_valid_in),
      .sample_in     (sense_sample_in),
      .acc_out       (cc_acc),
      .charge_out    (cc_chg),
      .discharge_out (cc_dis)
   );

   assign charge_out    = cc_chg;
   assign discharge_out = cc_dis;
   assign coulomb_out   = cc_acc;

   // Per-cell scaling then offset calibration
   for (genvar i = 0; i < gauge_pkg::CELLS; i++) begin : g_cell
      logic [31:0] prod;
      assign prod = cell_raw_in[i*gauge_pkg::CELL_W +: gauge_pkg::CELL_W]
                    * cell_gain_in;
      assign cal[i*gauge_pkg::CELL_W +: gauge_pkg::CELL_W] =
         prod[gauge_pkg::GAIN_SHIFT +: gauge_pkg::CELL_W] + cell_offset_in;
   end

   // Power mode and measurement scheduling
   always_comb begin
      shut     = mode_q == gauge_pkg::MODE_SHUT;
      sec_tick = sec_q == 32'(SEC_CYCLES - 1);
      // A zero interval is raised to SLP_MIN, so it is read as one second
      slp_eff  = (sleep_secs_in < gauge_pkg::SLP_MIN) ? gauge_pkg::SLP_MIN
                 : sleep_secs_in;
      slp_last = ({1'b0, slp_q} + 9'h001) >= {1'b0, slp_eff};
      sec_d    = (shut || sec_tick) ? 32'h0000_0000 : sec_q + 32'h1;
      slp_d    = 8'h00;
      if (mode_q == gauge_pkg::MODE_SLEEP) begin
         slp_d = slp_q;
         if (sec_tick) begin
            slp_d = slp_last ? 8'h00 : slp_q + 8'h01;
         end
      end
      cyc_now = sec_tick && ((mode_q == gauge_pkg::MODE_NORMAL) ||  // [R1]
                (mode_q == gauge_pkg::MODE_SLEEP && slp_last));     // [R2]
      cycle_d = cyc_now;
      // Idle between cycles, and always idle in shutdown
      lowp_d  = !cyc_now;                                           // [R1] [R2]
      mode_d  = mode_q;
      case (mode_q)
         gauge_pkg::MODE_NORMAL: begin
            if (sleep_req_in && !cc_chg && !cc_dis && !fault_in) begin
               mode_d = gauge_pkg::MODE_SLEEP;
            end
         end
         gauge_pkg::MODE_SLEEP: begin
            if (cc_chg || cc_dis || fault_in || fault2_in) begin
               mode_d = gauge_pkg::MODE_NORMAL;                     // [R3]
            end
         end
         gauge_pkg::MODE_SHUT: begin
            if (wake_in) begin
               mode_d = gauge_pkg::MODE_NORMAL;
            end
         end
         default: begin
            mode_d = gauge_pkg::MODE_NORMAL;
         end
      endcase
      if (shutdown_req_in) begin
         mode_d = gauge_pkg::MODE_SHUT;                             // [R4]
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode_q        <= gauge_pkg::MODE_NORMAL;
         sec_q         <= 32'h0000_0000;
         slp_q         <= 8'h00;
         cycle_out     <= 1'b0;
         low_power_out <= 1'b1;
      end else begin
         mode_q        <= mode_d;
         sec_q         <= sec_d;
         slp_q         <= slp_d;
         cycle_out     <= cycle_d;
         low_power_out <= lowp_d;
      end
   end

   assign mode_out = mode_q;

   // Presence, cell values, charge control and fault output
   always_comb begin
      present_d = present_out;
      if (sec_tick && !shut) begin
         present_d = !system_present_input_s_q[1];                                  // [R5]
      end
      cell_d = cyc_now ? cal : cell_v_out;                          // [R8]
      out_range = (temp_in < temp_min_in) || (temp_in > temp_max_in);
      inh_d   = shut ? charge_inhibit_out : out_range;              // [R16]
      bcast_d = cyc_now && mode_q == gauge_pkg::MODE_NORMAL && ready_d;
      bcur_d  = bcast_current_out;
      bvol_d  = bcast_voltage_out;
      if (bcast_d) begin
         // A suspended charge is announced as zero current
         bcur_d = out_range ? 16'h0000 : chg_current_in;            // [R14] [R16]
         bvol_d = chg_voltage_in;                                   // [R14]
      end
      // Latched until reset: the fuse cannot be unblown
      safe_d = safe_out || fault2_in;                               // [R13]
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         system_present_input_s_q           <= 2'h3;
         present_out        <= 1'b0;
         cell_v_out         <= 64'h0000_0000_0000_0000;
         charge_inhibit_out <= 1'b0;
         bcast_req_out      <= 1'b0;
         bcast_current_out  <= 16'h0000;
         bcast_voltage_out  <= 16'h0000;
         safe_out           <= 1'b0;
         pec_en_out         <= 1'b0;
      end else begin
         system_present_input_s_q           <= {system_present_input_s_q[0], system_present_input};
         present_out        <= present_d;
         cell_v_out         <= cell_d;
         charge_inhibit_out <= inh_d;
         bcast_req_out      <= bcast_d;
         bcast_current_out  <= bcur_d;
         bcast_voltage_out  <= bvol_d;
         safe_out           <= safe_d;
         pec_en_out         <= pec_enable_in;                       // [R15]
      end
   end

   // Bus supervision; link levels cross through two flip-flops
   always_comb begin
      off_d     = lnk2_q[0];
      ready_d   = !lnk2_q[0] && !shut;                              // [R11] [R12]
      abort_d   = lnk2_q[1] && !prev_q[0];                          // [R17]
      autocal_d = (lnk2_q[2] ^ prev_q[1]) && !shut;                 // [R9]
      rdy_wait_d = 32'h0000_0000;
      if (!bus_off_out && !bus_ready_out && !shut) begin
         rdy_wait_d = rdy_wait_q + 32'h1;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lnk1_q        <= 3'h0;
         lnk2_q        <= 3'h0;
         prev_q        <= 2'h0;
         bus_off_out   <= 1'b0;
         bus_ready_out <= 1'b0;
         bus_abort_out <= 1'b0;
         autocal_out   <= 1'b0;
         rdy_wait_q    <= 32'h0000_0000;
      end else begin
         lnk1_q        <= {lf_tgl, lf_idle, lf_off};
         lnk2_q        <= lnk1_q;
         prev_q        <= {lnk2_q[2], lnk2_q[1]};
         bus_off_out   <= off_d;
         bus_ready_out <= ready_d;
         bus_abort_out <= abort_d;
         autocal_out   <= autocal_d;
         rdy_wait_q    <= rdy_wait_d;
      end
   end

   default clocking cb_main @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   a_normal_cycle: assert property (mode_q == gauge_pkg::MODE_NORMAL // [R1]
      && sec_tick |=> cycle_out && !low_power_out)
      else $error("normal cycle missing");
   a_sleep_cycle: assert property (mode_q == gauge_pkg::MODE_SLEEP  // [R2]
      && sec_tick && !slp_last |=> !cycle_out && low_power_out)
      else $error("sleep cycle before interval");
   a_sleep_wake: assert property (mode_q == gauge_pkg::MODE_SLEEP   // [R3]
      && (cc_chg || fault_in) && !shutdown_req_in
      |=> mode_q == gauge_pkg::MODE_NORMAL)
      else $error("sleep not left on wake event");
   a_shut_quiet: assert property (mode_q == gauge_pkg::MODE_SHUT    // [R4]
      |=> !cycle_out && !bcast_req_out && !bus_ready_out)
      else $error("activity in shutdown");
   a_present_sample: assert property (sec_tick && !shut            // [R5]
      |=> present_out == !$past(system_present_input_s_q[1]))
      else $error("presence sample wrong");
   a_cell_update: assert property (cyc_now |=> cell_v_out ==        // [R8]
      $past(cal)) else $error("cell values not refreshed");
   a_ready_time: assert property (rdy_wait_q <                      // [R12]
      32'(READY_CYCLES)) else $error("bus not ready in time");
   a_fuse_hold: assert property (fault2_in |=> safe_out ##1 safe_out) // [R13]
      else $error("fuse output dropped");
   a_inhibit_bcast: assert property (bcast_req_out &&               // [R16]
      charge_inhibit_out |-> bcast_current_out == 16'h0000)
      else $error("current broadcast while inhibited");
   a_abort_pulse: assert property (bus_abort_out |=> !bus_abort_out) // [R17]
      else $error("abort longer than one cycle");

   c_sleep_wake: cover property (mode_q == gauge_pkg::MODE_SLEEP
      ##1 mode_q == gauge_pkg::MODE_NORMAL);
   c_bcast: cover property (bcast_req_out);
   c_autocal: cover property (autocal_out);
   c_bus_back: cover property (bus_off_out ##[1:20] bus_ready_out);
endmodule

// ===== smbus_partner.sv
// Far-side bus party: lines idle at the pull-up level or both held low
`timescale 1ns/1ns
module smbus_partner (
   input  wire logic lfo_clk_in,  // Slow clock for line changes
   input  wire logic hold_low_in, // Hold both lines low
   output logic      bus_clk_out, // Bus clock line level
   output logic      bus_data_out // Bus data line level
);
   // Released lines float up, so a quiet bus reads high
   initial begin
      bus_clk_out = 1'b1;
      bus_data_out = 1'b1;
   end
   always @(posedge lfo_clk_in) begin
      bus_clk_out <= !hold_low_in;
      bus_data_out <= !hold_low_in;
   end
endmodule

// ===== tb.sv
// Self-checking bench for the gauge scheduler and bus monitor
`timescale 1ns/1ns
module tb;
   localparam int SEC = 200;
   logic        clk_in, resetn_in, lfo_clk_in, bus_clk_in, bus_data_in;
   logic        system_present_input, sleep_req_in, shutdown_req_in;
   logic        wake_in, fault_in, fault2_in, sense_valid_in, hold_low;
   logic        pec_enable_in, cycle_out, low_power_out, present_out;
   logic        charge_out, discharge_out, autocal_out, bus_off_out;
   logic        bus_ready_out, bus_abort_out, safe_out, pec_en_out;
   logic        charge_inhibit_out, bcast_req_out;
   logic [2:0]  mode_out;
   logic [5:0]  w;
   logic [7:0]  sleep_secs_in;
   logic [15:0] sense_sample_in, cell_gain_in, cell_offset_in, temp_in, s;
   logic [15:0] temp_min_in, temp_max_in, chg_current_in, chg_voltage_in;
   logic [15:0] bcast_current_out, bcast_voltage_out;
   logic [47:0] coulomb_out;
   logic [63:0] cell_raw_in, cell_v_out, e;
   logic [31:0] rs = 32'hCC7DE893;
   longint      acc;
   int          err_count, samples_checked, g;
   gauge_scheduler_bus_monitor #(.SEC_CYCLES(SEC), .BUSOFF_LF(40),
      .AUTOCAL_LF(100)) dut_u (.clk_in, .resetn_in, .lfo_clk_in,
      .bus_clk_in, .bus_data_in, .system_present_input, .sleep_req_in,
      .shutdown_req_in, .wake_in, .sleep_secs_in, .fault_in, .fault2_in,
      .sense_valid_in, .sense_sample_in, .cell_raw_in, .cell_gain_in,
      .cell_offset_in, .temp_in, .temp_min_in, .temp_max_in,
      .chg_current_in, .chg_voltage_in, .pec_enable_in, .mode_out,
      .cycle_out, .low_power_out, .present_out, .charge_out,
      .discharge_out, .coulomb_out, .cell_v_out, .autocal_out,
      .bus_off_out, .bus_ready_out, .bus_abort_out, .safe_out,
      .charge_inhibit_out, .bcast_req_out, .bcast_current_out,
      .bcast_voltage_out, .pec_en_out);
   smbus_partner pm_u (.lfo_clk_in, .hold_low_in(hold_low),
      .bus_clk_out(bus_clk_in), .bus_data_out(bus_data_in));
   assign w = {safe_out, bus_abort_out, bus_ready_out, autocal_out,
               bus_off_out, cycle_out};
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // Odd start offset keeps the slow clock out of phase with clk_in
   initial begin
      lfo_clk_in = 1'b0;
      #13;
      forever #32 lfo_clk_in = ~lfo_clk_in;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [63:0] a, input logic [63:0] x);
      samples_checked++;
      if (a !== x) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, a, x);
      end
   endtask
   // Bounded wait for a watched output; ok=0 means it must not show
   task automatic wt(input int i, input logic v, input int n,
                     input logic ok = 1'b1);
      int k;
      k = 0;
      do begin
         @(negedge clk_in);
         k++;
      end while (w[i] !== v && k < n);
      chk(w[i] === v, ok);
   endtask
   task automatic per(output int n);
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (cycle_out !== 1'b1 && n < 2000);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      tally_and_finish();
   end
   initial begin
      // Set in the update region so every reset branch sees the fall
      resetn_in <= 1'b0;
      {sleep_req_in, shutdown_req_in, wake_in, fault_in} = 0;
      {fault2_in, sense_valid_in, pec_enable_in, hold_low} = 0;
      {system_present_input, sleep_secs_in, sense_sample_in} = 0;
      {cell_raw_in, cell_gain_in, cell_offset_in, temp_in} = 0;
      {temp_min_in, temp_max_in, chg_current_in, chg_voltage_in} = 0;
      {err_count, samples_checked, acc} = 0;
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(negedge clk_in);
      chk({mode_out, low_power_out}, 4'h3);
      @(posedge clk_in);
      rs = xs(rs);
      cell_raw_in <= {rs, ~rs};
      {cell_gain_in, cell_offset_in} <= {rs[31:16] | 16'h4000, 16'h0011};
      {temp_in, temp_min_in, temp_max_in} <= {16'h0100, 16'h0050, 16'h0200};
      {chg_current_in, chg_voltage_in} <= {16'h0BB8, rs[15:0]};
      {pec_enable_in, sleep_secs_in} <= 9'h103;
      wt(0, 1'b1, 400);
      for (int i = 0; i < 4; i++)
         e[16*i+:16] = 16'(((longint'(cell_raw_in[16*i+:16]) *
                       cell_gain_in) >> 15) + cell_offset_in);
      chk(cell_v_out, e);
      chk({present_out, low_power_out, pec_en_out}, 3'h5);
      chk({bcast_req_out, bcast_current_out, bcast_voltage_out},
          {1'b1, chg_current_in, chg_voltage_in});
      @(posedge clk_in);
      temp_in <= 16'h0300;
      per(g);
      chk(g, SEC);
      chk({charge_inhibit_out, bcast_current_out}, 17'h10000);
      for (int k = 0; k < 21; k++) begin
         @(posedge clk_in);
         rs = xs(rs);
         s = (k == 20) ? 16'h0000 : rs[15:0];
         {sense_valid_in, sense_sample_in} <= {1'b1, s};
         acc += longint'($signed(s));
         @(posedge clk_in);
         sense_valid_in <= 1'b0;
         @(negedge clk_in);
         chk(coulomb_out, 48'(acc));
         chk({charge_out, discharge_out},
             {$signed(s) > 0, $signed(s) < 0});
      end
      @(posedge clk_in);
      sleep_req_in <= 1'b1;
      wt(0, 1'b1, 800);
      per(g);
      chk({mode_out, 32'(g)}, {3'h2, 32'(3 * SEC)});
      @(posedge clk_in);
      {sense_valid_in, sense_sample_in} <= {1'b1, 16'h0001};
      @(posedge clk_in);
      sense_valid_in <= 1'b0;
      repeat (3) @(negedge clk_in);
      chk(mode_out, 3'h1);
      @(posedge clk_in);
      shutdown_req_in <= 1'b1;
      wt(0, 1'b1, 450, 1'b0);
      chk({mode_out, bus_ready_out}, 4'h8);
      @(posedge clk_in);
      {shutdown_req_in, wake_in, sleep_req_in} <= 3'h2;
      @(posedge clk_in);
      {wake_in, hold_low} <= 2'h1;
      wt(1, 1'b1, 500, 1'b0);
      wt(1, 1'b1, 1500);
      chk(bus_ready_out, 1'b0);
      wt(2, 1'b1, 1500);
      @(posedge clk_in);
      hold_low <= 1'b0;
      wt(1, 1'b0, 100);
      wt(3, 1'b1, 250);
      wt(4, 1'b1, 30000);
      @(posedge clk_in);
      fault2_in <= 1'b1;
      @(posedge clk_in);
      fault2_in <= 1'b0;
      repeat (20) @(negedge clk_in);
      chk(safe_out, 1'b1);
      tally_and_finish();
   end
endmodule
